//--- dv/vbc_pair_props.sv
/*
 * assertions on the register link between host and device ends and on
 * the link and load outputs of the device end.
 * assumes one mclk domain and an instance beside the link interface.
 */
`timescale 1ns/100ps
`default_nettype none
module vbc_pair_props (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic wr_stb,
	input wire logic rd_stb,
	input wire vbc_pkg::vbc_word_type rdata,
	input wire logic rvalid,
	input wire logic link_clk,
	input wire logic link_en,
	input wire logic mod_frac_load,
	input wire logic presc_load,
	input wire logic cal_busy
);
	import vbc_pkg::*;
	logic [4:0] bit_cnt;
	logic [4:0] next_bit_cnt;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	// ****************************************
	// frame bit counter
	// ****************************************
	// counts link clocks inside a frame; a gap clears it for the next one
	always_comb begin
		next_bit_cnt = link_en ? bit_cnt + 5'(link_clk) : 5'h00;
	end
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			bit_cnt <= 5'h00;
		end else begin
			bit_cnt <= next_bit_cnt;
		end
	end
	sequence s_answer;
		rvalid;
	endsequence
	sequence s_frame_end;
		$fell(link_en);
	endsequence
	property p_rd_answer;
		rd_stb |=> s_answer;
	endproperty
	property p_rvalid_cause;
		rvalid |-> $past(rd_stb);
	endproperty
	property p_rdata_hold;
		!rvalid |-> $stable(rdata);
	endproperty
	property p_one_strobe;
		!(wr_stb && rd_stb);
	endproperty
	property p_clk_in_frame;
		link_clk |-> link_en;
	endproperty
	property p_frame_len;
		s_frame_end |-> bit_cnt == 5'h10;
	endproperty
	property p_frac_pulse;
		mod_frac_load |=> !mod_frac_load;
	endproperty
	property p_presc_pulse;
		presc_load |=> !presc_load;
	endproperty
	property p_busy_frame;
		$rose(link_en) |-> cal_busy;
	endproperty
	a_rd_answer: assert property (p_rd_answer)
		else $error("read strobe without answer");
	a_rvalid_cause: assert property (p_rvalid_cause)
		else $error("read answer without strobe");
	a_rdata_hold: assert property (p_rdata_hold)
		else $error("read data moved between reads");
	a_one_strobe: assert property (p_one_strobe)
		else $error("read and write strobes together");
	a_clk_in_frame: assert property (p_clk_in_frame)
		else $error("link clock outside a frame");
	a_frame_len: assert property (p_frame_len)
		else $error("link frame is not sixteen bits");
	a_frac_pulse: assert property (p_frac_pulse)
		else $error("fraction load longer than one cycle");
	a_presc_pulse: assert property (p_presc_pulse)
		else $error("prescaler load longer than one cycle");
	a_busy_frame: assert property (p_busy_frame)
		else $error("link frame while engine idle");
endmodule // vbc_pair_props
`default_nettype wire

//--- dv/vco_band_calibration_fsm_tb.sv
/*
 * bench of the vco band calibration pair: both ends on one link, a vco
 * model on vco_tick that slows as the switch rises, one task per case.
 * assumes the design files and the checker are compiled before it.
 */
`include "vbc_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin \
	comparisons++; \
	if ((a) !== (b)) begin \
		n_errors++; \
		$display("unexpected at %0t: %h vs %h", $time, a, b); \
	end \
end
module vco_band_calibration_fsm_tb;
	import vbc_pkg::*;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic hop_req = 1'b0;
	logic hop_manual = 1'b0;
	logic hop_int_changed = 1'b0;
	logic [18:0] hop_int = 19'h0_0000;
	logic [23:0] hop_frac = 24'h00_0000;
	logic [7:0] hop_sw = 8'h00;
	logic [23:0] hop_link_keep = 24'h00_0005;
	logic raw_req = 1'b0;
	logic raw_rd = 1'b0;
	logic [5:0] raw_addr = 6'h00;
	logic [23:0] raw_data = 24'h00_0000;
	logic vco_tick = 1'b0;
	logic lock_detect = 1'b1;
	logic link_clk, link_data, link_en, mod_frac_load, presc_load;
	logic cal_busy, req_ready, rd_valid;
	logic [23:0] mod_frac, rd_word;
	logic [18:0] presc_int;
	logic [15:0] word = 16'h0000;
	logic [15:0] frame_word = 16'h0000;
	logic [11:0] wlog = 12'h000;
	logic [4:0] acc = 5'h00;
	logic [5:0] sum;
	logic en_d = 1'b0;
	int cyc, frames, last_clk, gap, n_fload, n_pload, f0, n0, n_rd;
	int n_errors, comparisons;
	vbc_link_if link_bus();
	vbc_device #(.SW_BITS(5)) i_vbc_device (.mclk(mclk), .rst_n(rst_n),
		.bus(link_bus), .vco_tick(vco_tick), .lock_detect(lock_detect),
		.link_clk(link_clk), .link_data(link_data), .link_en(link_en),
		.mod_frac(mod_frac), .mod_frac_load(mod_frac_load),
		.presc_int(presc_int), .presc_load(presc_load),
		.cal_busy(cal_busy));
	vbc_host i_vbc_host (.mclk(mclk), .rst_n(rst_n), .bus(link_bus),
		.hop_req(hop_req), .hop_manual(hop_manual),
		.hop_int_changed(hop_int_changed), .hop_int(hop_int),
		.hop_frac(hop_frac), .hop_sw(hop_sw),
		.hop_link_keep(hop_link_keep), .raw_req(raw_req),
		.raw_rd(raw_rd), .raw_addr(raw_addr), .raw_data(raw_data),
		.req_ready(req_ready), .rd_word(rd_word), .rd_valid(rd_valid));
	vbc_pair_props i_vbc_pair_props (.mclk(mclk), .rst_n(rst_n),
		.wr_stb(link_bus.wr_stb), .rd_stb(link_bus.rd_stb),
		.rdata(link_bus.rdata), .rvalid(link_bus.rvalid),
		.link_clk(link_clk), .link_en(link_en),
		.mod_frac_load(mod_frac_load), .presc_load(presc_load),
		.cal_busy(cal_busy));
	// ****************************************
	// clock, vco model and link monitor
	// ****************************************
	always #10 mclk = ~mclk;
	// vco rate is (32 - switch)/32 of mclk, so the search has one best fit
	assign sum = {1'b0, acc} + (6'h20 - {1'b0, frame_word[11:7]});
	// frames are decoded here so every case sees the same switch history
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		en_d <= link_en;
		acc <= sum[4:0];
		vco_tick <= sum[5];
		if (link_clk) begin
			word <= {word[14:0], link_data};
			gap <= cyc - last_clk;
			last_clk <= cyc;
		end
		if (en_d && !link_en) begin
			frames <= frames + 1;
			frame_word <= word;
		end
		if (link_bus.wr_stb) begin
			wlog <= {wlog[5:0], link_bus.addr};
		end
		n_fload <= n_fload + int'(mod_frac_load);
		n_pload <= n_pload + int'(presc_load);
		n_rd <= n_rd + int'(rd_valid);
		if (cyc > 60000) begin
			n_errors++;
			final_report();
		end
	end
	// ****************************************
	// driver tasks and cases
	// ****************************************
	task wait_ready;
		for (int i = 0; i < 200 && req_ready !== 1'b1; i++) @(negedge mclk);
	endtask
	task raw(input logic rd, input vbc_addr_type a, input vbc_word_type d);
		wait_ready();
		@(posedge mclk);
		raw_req <= 1'b1;
		raw_rd <= rd;
		raw_addr <= a;
		raw_data <= d;
		@(posedge mclk);
		raw_req <= 1'b0;
		@(negedge mclk);
		wait_ready();
		repeat (4) @(negedge mclk);
	endtask
	task hop(input logic man, input logic chg, input logic [18:0] i,
		input vbc_word_type f, input logic [7:0] s);
		wait_ready();
		@(posedge mclk);
		hop_req <= 1'b1;
		hop_manual <= man;
		hop_int_changed <= chg;
		hop_int <= i;
		hop_frac <= f;
		hop_sw <= s;
		@(posedge mclk);
		hop_req <= 1'b0;
		@(negedge mclk);
		wait_ready();
		repeat (2) @(negedge mclk); // last write strobe still stands at ready
	endtask
	// engine may already be busy when the request returns
	task cal_wait;
		for (int i = 0; i < 20 && cal_busy !== 1'b1; i++) @(negedge mclk);
		for (int i = 0; i < 8000 && cal_busy !== 1'b0; i++) @(negedge mclk);
		repeat (4) @(negedge mclk);
	endtask
	task t_regs;
		raw(1'b1, `VBC_REG_RDIV, 24'h00_0000);
		`CHK(rd_word, 24'h00_0001)
		raw(1'b1, 6'h3f, 24'h00_0000);
		`CHK(rd_word, 24'h00_0000)
		raw(1'b0, `VBC_REG_RDIV, 24'h00_0010);
		raw(1'b0, `VBC_REG_VLINK, 24'h00_0005);
		raw(1'b0, `VBC_REG_MODE, 24'h00_0800);
		raw(1'b0, `VBC_REG_CALCFG, 24'h00_0044);
		raw(1'b1, `VBC_REG_CALCFG, 24'h00_0000);
		`CHK(rd_word, 24'h00_0044)
		`CHK(n_rd, 3)
	endtask
	// window 16*32 cycles, expected 258 counts: switch 16 fits best
	task t_auto;
		f0 = frames;
		hop(1'b0, 1'b1, 19'h0_0008, 24'h10_0000, 8'h00);
		`CHK(mod_frac, 24'h00_0000)
		`CHK(wlog, {`VBC_REG_INTG, `VBC_REG_FRAC})
		cal_wait();
		`CHK(frames - f0, 6)
		`CHK(mod_frac, 24'h10_0000)
		`CHK(frame_word[14:7], 8'h10)
		`CHK(frame_word[6:0], 7'h05)
		raw(1'b1, `VBC_REG_STATUS, 24'h00_0000);
		`CHK(rd_word, 24'h00_0010)
	endtask
	task t_same;
		f0 = frames;
		n0 = n_fload;
		hop(1'b0, 1'b0, 19'h0_0008, 24'h10_0000, 8'h00);
		cal_wait();
		`CHK(frames - f0, 6)
		`CHK(n_fload - n0, 1)
		`CHK(mod_frac, 24'h10_0000)
	endtask
	task t_int;
		raw(1'b0, `VBC_REG_MODE, 24'h00_0000);
		f0 = frames;
		n0 = n_pload;
		hop(1'b0, 1'b1, 19'h0_0008, 24'h10_0000, 8'h00);
		cal_wait();
		`CHK(frames - f0, 6)
		`CHK(n_pload - n0, 1)
		`CHK(presc_int, 19'h0_0008)
	endtask
	// engine clock at reference/4 while the switch is set by hand
	task t_manual;
		raw(1'b0, `VBC_REG_MODE, 24'h00_0800);
		raw(1'b0, `VBC_REG_CALCFG, 24'h00_2844);
		f0 = frames;
		n0 = n_fload;
		hop(1'b1, 1'b0, 19'h0_0008, 24'h20_0000, 8'h0a);
		`CHK(wlog, {`VBC_REG_VLINK, `VBC_REG_FRAC})
		repeat (200) @(negedge mclk);
		`CHK(frames - f0, 1)
		`CHK(frame_word[14:7], 8'h0a)
		`CHK(frame_word[6:0], 7'h05)
		`CHK(gap, 4)
		`CHK(n_fload - n0, 1)
		`CHK(mod_frac, 24'h20_0000)
	endtask
	task t_relock;
		raw(1'b0, `VBC_REG_CALCFG, 24'h00_0044);
		raw(1'b0, `VBC_REG_LOCK, 24'h00_2000);
		f0 = frames;
		@(posedge mclk);
		lock_detect <= 1'b0;
		cal_wait();
		`CHK(frames - f0, 6)
		@(posedge mclk);
		lock_detect <= 1'b1;
		repeat (5) @(posedge mclk);
		lock_detect <= 1'b0;
		repeat (3000) @(negedge mclk);
		`CHK(frames - f0, 6)
	endtask
	task final_report;
		$display("comparisons %0d, n_errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (2) @(negedge mclk);
		t_regs();
		t_auto();
		t_same();
		t_int();
		t_manual();
		t_relock();
		final_report();
	end
endmodule // vco_band_calibration_fsm_tb
`default_nettype wire

//--- hdl/vbc_cfg.svh
/*
 * constants of the vco band calibration pair: register offsets, field
 * positions, reset values and timing counts.
 * assumes it is included by bare name wherever a figure is needed.
 */
`ifndef VBC_CFG_SVH
`define VBC_CFG_SVH

// ****************************************************
// register offsets
// ****************************************************
`define VBC_REG_RDIV 6'h02
`define VBC_REG_INTG 6'h03
`define VBC_REG_FRAC 6'h04
`define VBC_REG_VLINK 6'h05
`define VBC_REG_MODE 6'h06
`define VBC_REG_LOCK 6'h07
`define VBC_REG_CALCFG 6'h0a
`define VBC_REG_STATUS 6'h10

// ****************************************************
// field positions
// ****************************************************
`define VBC_MODE_FRAC_BIT 11
`define VBC_RELOCK_BIT 13
`define VBC_CAL_DIS_BIT 11
`define VBC_N_LO 0
`define VBC_N_HI 2
`define VBC_K_LO 6
`define VBC_K_HI 7
`define VBC_M_LO 13
`define VBC_M_HI 14
`define VBC_VLINK_KEEP_HI 6
`define VBC_FRAC_BITS 24

// ****************************************************
// reset values
// ****************************************************
`define VBC_RST_RDIV 14'h0001
`define VBC_RST_WORD 24'h00_0000
`define VBC_RST_SW 8'h00

// ****************************************************
// timing
// ****************************************************
`define VBC_MCLK_HZ 50000000
`define VBC_CAL_CLK_MAX_HZ 50000000
`define VBC_WAIT_UNIT 128
`define VBC_LINK_SLOTS 20
`define VBC_LINK_BITS 16

`endif

//--- hdl/vbc_device.sv
/*
 * synthesizer end: register file, vco band search engine and the
 * internal serial link towards the vco subsystem.
 * assumes mclk is the reference clock and vco_tick pulses once per
 * counted vco cycle, synchronous to mclk.
 */
// What this block does
// - calibrate once per frequency change when enabled
// - send switch via link word, address untouched
// - host sets link address and id first
// - relock option reruns calibration exactly once
// - selected switch readable in status register
// - cal disabled: link writes go straight out
// - link transfer takes sixteen link clocks
// - engine clock is reference over 1/4/16/32
// - host keeps engine clock at most 50 MHz
// - fractional write calibrates, loads modulator after
// - cal disabled: fractional value loads at once
// - integer mode: integer write calibrates then loads
// - same-value rewrite reruns calibration again
// - window is reference period times R times 2^n
// - expected count is floor of N times 2^n
// - five-bit bank, measurements, 20-clock transfers
// - k times 128 wait clocks per calibration
// - host writes fraction each change, integer if changed
// - manual: switch transfer first, then frequency
`include "vbc_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module vbc_device #(
	parameter int SW_BITS = 5
) (
	input wire logic mclk,
	input wire logic rst_n,
	vbc_link_if.dev bus,
	input wire logic vco_tick,
	input wire logic lock_detect,
	output logic link_clk,
	output logic link_data,
	output logic link_en,
	output logic [23:0] mod_frac,
	output logic mod_frac_load,
	output logic [18:0] presc_int,
	output logic presc_load,
	output logic cal_busy
);
	import vbc_pkg::*;

	// ****************************************************
	// decode helpers
	// ****************************************************
	// engine clock divider mask for codes 0..3 (divide 1, 4, 16, 32)
	function automatic logic [4:0] div_mask(input logic [1:0] code);
		case (code)
			2'd0: div_mask = 5'h00;
			2'd1: div_mask = 5'h03;
			2'd2: div_mask = 5'h0f;
			default: div_mask = 5'h1f;
		endcase
	endfunction
	// window exponent: codes above 3 skip n = 4
	function automatic logic [3:0] win_exp(input logic [2:0] code);
		win_exp = (code > 3'd3) ? {1'b0, code} + 4'd1 : {1'b0, code};
	endfunction

	// ****************************************************
	// state
	// ****************************************************
	logic [13:0] rdiv, next_rdiv;
	logic [18:0] intg, next_intg;
	logic [23:0] frac, next_frac, vlink, next_vlink, mode, next_mode;
	logic [23:0] lockcfg, next_lockcfg, calcfg, next_calcfg;
	logic [7:0] sw_status, next_sw_status;
	logic [4:0] div_cnt, next_div_cnt;
	logic tick, next_tick;
	vbc_state_type state, next_state;
	logic [2:0] bit_idx, next_bit_idx;
	logic [7:0] trial, next_trial, best, next_best;
	logic [26:0] best_err, next_best_err, vcount, next_vcount;
	logic [21:0] wcnt, next_wcnt;
	logic [9:0] wait_cnt, next_wait_cnt;
	logic [15:0] shreg, next_shreg;
	logic [4:0] slot, next_slot;
	logic final_q, next_final_q, manual_q, next_manual_q;
	logic pend_frac, next_pend_frac, pend_int, next_pend_int;
	logic relock_used, next_relock_used, lock_q, next_lock_q;
	logic next_link_clk, next_link_data, next_link_en;
	logic [23:0] next_mod_frac, rdata_q, next_rdata_q;
	logic next_mod_frac_load, next_presc_load, rvalid_q, next_rvalid_q;
	logic [18:0] next_presc_int;
	logic [50:0] scaled;
	logic [26:0] expected, diff;
	logic cal_off, frac_mode, wr_int, wr_frac, wr_link, relock_go;

	assign cal_off = calcfg[`VBC_CAL_DIS_BIT];
	assign frac_mode = mode[`VBC_MODE_FRAC_BIT];
	assign wr_int = bus.wr_stb && bus.addr == `VBC_REG_INTG;
	assign wr_frac = bus.wr_stb && bus.addr == `VBC_REG_FRAC;
	assign wr_link = bus.wr_stb && bus.addr == `VBC_REG_VLINK;
	// expected count: integer and fraction scaled by 2^n, fraction dropped
	assign scaled = {8'h00, intg, frac} << win_exp(calcfg[`VBC_N_HI:`VBC_N_LO]);
	assign expected = scaled[50:`VBC_FRAC_BITS];
	assign diff = (vcount > expected) ? vcount - expected : expected - vcount;
	// relock fires on the falling lock indication, once per frequency
	assign relock_go = lockcfg[`VBC_RELOCK_BIT] && lock_q && !lock_detect
		&& !relock_used && !cal_off;

	assign bus.rdata = rdata_q;
	assign bus.rvalid = rvalid_q;

	// ****************************************************
	// next-state logic of registers, divider, engine and link
	// ****************************************************
	always_comb begin
		next_rdiv = rdiv;
		next_intg = intg;
		next_frac = frac;
		next_vlink = vlink;
		next_mode = mode;
		next_lockcfg = lockcfg;
		next_calcfg = calcfg;
		next_sw_status = sw_status;
		next_state = state;
		next_bit_idx = bit_idx;
		next_trial = trial;
		next_best = best;
		next_best_err = best_err;
		next_vcount = vcount;
		next_wcnt = wcnt;
		next_wait_cnt = wait_cnt;
		next_shreg = shreg;
		next_slot = slot;
		next_final_q = final_q;
		next_manual_q = manual_q;
		next_pend_frac = pend_frac;
		next_pend_int = pend_int;
		next_relock_used = relock_used;
		next_lock_q = lock_detect;
		next_link_clk = 1'b0;
		next_link_data = link_data;
		next_link_en = link_en;
		next_mod_frac = mod_frac;
		next_mod_frac_load = 1'b0;
		next_presc_int = presc_int;
		next_presc_load = 1'b0;
		next_rvalid_q = bus.rd_stb;
		next_rdata_q = rdata_q;
		// engine clock enable from the reference
		next_tick = (div_cnt == div_mask(calcfg[`VBC_M_HI:`VBC_M_LO]));
		next_div_cnt = next_tick ? 5'h00 : div_cnt + 5'h01;
		// register reads; the status word carries the selected switch
		if (bus.rd_stb) begin
			case (bus.addr)
				`VBC_REG_RDIV: next_rdata_q = {10'h000, rdiv};
				`VBC_REG_INTG: next_rdata_q = {5'h00, intg};
				`VBC_REG_FRAC: next_rdata_q = frac;
				`VBC_REG_VLINK: next_rdata_q = vlink;
				`VBC_REG_MODE: next_rdata_q = mode;
				`VBC_REG_LOCK: next_rdata_q = lockcfg;
				`VBC_REG_CALCFG: next_rdata_q = calcfg;
				`VBC_REG_STATUS: next_rdata_q = {16'h0000, sw_status};
				default: next_rdata_q = `VBC_RST_WORD;
			endcase
		end
		// register writes
		if (bus.wr_stb) begin
			case (bus.addr)
				`VBC_REG_RDIV: next_rdiv = bus.wdata[13:0];
				`VBC_REG_INTG: next_intg = bus.wdata[18:0];
				`VBC_REG_FRAC: next_frac = bus.wdata;
				`VBC_REG_VLINK: next_vlink = bus.wdata;
				`VBC_REG_MODE: next_mode = bus.wdata;
				`VBC_REG_LOCK: next_lockcfg = bus.wdata;
				`VBC_REG_CALCFG: next_calcfg = bus.wdata;
				default: next_rdiv = rdiv;
			endcase
		end
		// engine sequencing
		case (state)
			VBC_IDLE: begin
				next_link_en = 1'b0;
			end
			VBC_WAIT: begin
				if (tick) begin
					if (wait_cnt <= 10'h001) begin
						next_state = VBC_SEND;
						next_shreg = {1'b0, trial, vlink[`VBC_VLINK_KEEP_HI:0]};
						next_slot = 5'h00;
					end else begin
						next_wait_cnt = wait_cnt - 10'h001;
					end
				end
			end
			VBC_SEND: begin
				// 16 clocked bits, then idle slots up to 20 engine clocks
				if (tick) begin
					next_link_en = (slot < 5'(`VBC_LINK_BITS));
					if (slot < 5'(`VBC_LINK_BITS)) begin
						next_link_data = shreg[15];
						next_link_clk = 1'b1;
						next_shreg = {shreg[14:0], 1'b0};
					end
					next_slot = slot + 5'h01;
					if (slot == 5'(`VBC_LINK_SLOTS - 1)) begin
						next_link_en = 1'b0;
						if (manual_q || final_q) begin
							next_state = VBC_IDLE;
						end else begin
							next_state = VBC_MEAS;
							next_vcount = 27'h000_0000;
							next_wcnt = 22'({8'h00, rdiv} <<
								win_exp(calcfg[`VBC_N_HI:`VBC_N_LO]));
						end
						// calibration over: publish switch and load frequency
						if (final_q) begin
							next_sw_status = trial;
							if (pend_frac) begin
								next_mod_frac = frac;
								next_mod_frac_load = 1'b1;
							end
							if (pend_int) begin
								next_presc_int = intg;
								next_presc_load = 1'b1;
							end
							next_pend_frac = 1'b0;
							next_pend_int = 1'b0;
						end
					end
				end
			end
			VBC_MEAS: begin
				// count vco cycles over the reference-timed window
				if (vco_tick) begin
					next_vcount = vcount + 27'h000_0001;
				end
				if (wcnt <= 22'h00_0001) begin
					next_state = VBC_DECIDE;
				end
				next_wcnt = wcnt - 22'h00_0001;
			end
			VBC_DECIDE: begin
				next_state = VBC_SEND;
				next_slot = 5'h00;
				// keep the closest trial; too fast means keep the bit set
				if (diff < best_err) begin
					next_best = trial;
					next_best_err = diff;
				end
				if (vcount <= expected) begin
					next_trial[bit_idx] = 1'b0;
				end
				if (bit_idx == 3'd0) begin
					next_final_q = 1'b1;
					next_trial = (diff < best_err) ? trial : best;
				end else begin
					next_bit_idx = bit_idx - 3'd1;
					next_trial[bit_idx - 3'd1] = 1'b1;
				end
				next_shreg = {1'b0, next_trial, vlink[`VBC_VLINK_KEEP_HI:0]};
			end
			default: next_state = VBC_IDLE;
		endcase
		// calibration start: frequency write or single relock attempt
		if ((wr_frac && frac_mode) || (wr_int && !frac_mode) || relock_go) begin
			if (cal_off) begin
				if (wr_frac && frac_mode) begin
					next_mod_frac = bus.wdata;
					next_mod_frac_load = 1'b1;
				end
				if (wr_int) begin
					next_presc_int = bus.wdata[18:0];
					next_presc_load = 1'b1;
				end
			end else begin
				next_state = VBC_WAIT;
				next_wait_cnt = 10'({calcfg[`VBC_K_HI:`VBC_K_LO], 7'h00});
				next_bit_idx = 3'(SW_BITS - 1);
				next_trial = 8'h00;
				next_trial[SW_BITS - 1] = 1'b1;
				next_best = 8'h00;
				next_best_err = 27'h7ff_ffff;
				next_final_q = 1'b0;
				next_manual_q = 1'b0;
				next_link_en = 1'b0;
				next_pend_frac = pend_frac || (wr_frac && frac_mode);
				next_pend_int = pend_int || (wr_int && !frac_mode);
				next_relock_used = relock_go;
			end
		end else if (wr_link && cal_off) begin
			// manual switch word goes out unchanged, no search
			next_state = VBC_SEND;
			next_shreg = bus.wdata[15:0];
			next_slot = 5'h00;
			next_manual_q = 1'b1;
			next_final_q = 1'b0;
		end
	end

	// ****************************************************
	// registers
	// ****************************************************
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rdiv <= `VBC_RST_RDIV;
			intg <= 19'h0_0000;
			frac <= `VBC_RST_WORD;
			vlink <= `VBC_RST_WORD;
			mode <= `VBC_RST_WORD;
			lockcfg <= `VBC_RST_WORD;
			calcfg <= `VBC_RST_WORD;
			sw_status <= `VBC_RST_SW;
			div_cnt <= 5'h00;
			tick <= 1'b0;
			state <= VBC_IDLE;
			bit_idx <= 3'd0;
			trial <= 8'h00;
			best <= 8'h00;
			best_err <= 27'h000_0000;
			vcount <= 27'h000_0000;
			wcnt <= 22'h00_0000;
			wait_cnt <= 10'h000;
			shreg <= 16'h0000;
			slot <= 5'h00;
			final_q <= 1'b0;
			manual_q <= 1'b0;
			pend_frac <= 1'b0;
			pend_int <= 1'b0;
			relock_used <= 1'b0;
			lock_q <= 1'b0;
			link_clk <= 1'b0;
			link_data <= 1'b0;
			link_en <= 1'b0;
			mod_frac <= `VBC_RST_WORD;
			mod_frac_load <= 1'b0;
			presc_int <= 19'h0_0000;
			presc_load <= 1'b0;
			rdata_q <= `VBC_RST_WORD;
			rvalid_q <= 1'b0;
			cal_busy <= 1'b0;
		end else begin
			rdiv <= next_rdiv;
			intg <= next_intg;
			frac <= next_frac;
			vlink <= next_vlink;
			mode <= next_mode;
			lockcfg <= next_lockcfg;
			calcfg <= next_calcfg;
			sw_status <= next_sw_status;
			div_cnt <= next_div_cnt;
			tick <= next_tick;
			state <= next_state;
			bit_idx <= next_bit_idx;
			trial <= next_trial;
			best <= next_best;
			best_err <= next_best_err;
			vcount <= next_vcount;
			wcnt <= next_wcnt;
			wait_cnt <= next_wait_cnt;
			shreg <= next_shreg;
			slot <= next_slot;
			final_q <= next_final_q;
			manual_q <= next_manual_q;
			pend_frac <= next_pend_frac;
			pend_int <= next_pend_int;
			relock_used <= next_relock_used;
			lock_q <= next_lock_q;
			link_clk <= next_link_clk;
			link_data <= next_link_data;
			link_en <= next_link_en;
			mod_frac <= next_mod_frac;
			mod_frac_load <= next_mod_frac_load;
			presc_int <= next_presc_int;
			presc_load <= next_presc_load;
			rdata_q <= next_rdata_q;
			rvalid_q <= next_rvalid_q;
			cal_busy <= (next_state != VBC_IDLE);
		end
	end
endmodule // vbc_device
`default_nettype wire

//--- hdl/vbc_host.sv
/*
 * host end: turns frequency-change and raw write requests into ordered
 * register writes on the link, and returns register reads.
 * assumes the device end sits on the same mclk.
 */
`include "vbc_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module vbc_host (
	input wire logic mclk,
	input wire logic rst_n,
	vbc_link_if.host bus,
	input wire logic hop_req,
	input wire logic hop_manual,
	input wire logic hop_int_changed,
	input wire logic [18:0] hop_int,
	input wire logic [23:0] hop_frac,
	input wire logic [7:0] hop_sw,
	input wire logic [23:0] hop_link_keep,
	input wire logic raw_req,
	input wire logic raw_rd,
	input wire logic [5:0] raw_addr,
	input wire logic [23:0] raw_data,
	output logic req_ready,
	output logic [23:0] rd_word,
	output logic rd_valid
);
	import vbc_pkg::*;

	// ****************************************************
	// sequencer
	// ****************************************************
	vbc_hstate_type state, next_state;
	logic wr_q, next_wr_q, rd_q, next_rd_q;
	logic [5:0] addr_q, next_addr_q;
	logic [23:0] data_q, next_data_q;
	logic next_req_ready;

	assign bus.wr_stb = wr_q;
	assign bus.rd_stb = rd_q;
	assign bus.addr = addr_q;
	assign bus.wdata = data_q;

	// one write per cycle; the hop order is switch, integer, fraction
	always_comb begin
		next_state = state;
		next_wr_q = 1'b0;
		next_rd_q = 1'b0;
		next_addr_q = addr_q;
		next_data_q = data_q;
		case (state)
			VBC_H_IDLE: begin
				if (hop_req) begin
					next_state = hop_manual ? VBC_H_SW : VBC_H_INT;
				end else if (raw_req) begin
					next_state = VBC_H_RAW;
				end
			end
			VBC_H_SW: begin
				// manual hop: switch word precedes the frequency
				next_wr_q = 1'b1;
				next_addr_q = `VBC_REG_VLINK;
				next_data_q = {hop_link_keep[23:16], 1'b0, hop_sw,
					hop_link_keep[`VBC_VLINK_KEEP_HI:0]};
				next_state = VBC_H_INT;
			end
			VBC_H_INT: begin
				// integer only when its part changed
				next_wr_q = hop_int_changed;
				next_addr_q = `VBC_REG_INTG;
				next_data_q = {5'h00, hop_int};
				next_state = VBC_H_FRAC;
			end
			VBC_H_FRAC: begin
				next_wr_q = 1'b1;
				next_addr_q = `VBC_REG_FRAC;
				next_data_q = hop_frac;
				next_state = VBC_H_IDLE;
			end
			VBC_H_RAW: begin
				next_wr_q = !raw_rd;
				next_rd_q = raw_rd;
				next_addr_q = raw_addr;
				next_data_q = raw_data;
				next_state = VBC_H_IDLE;
			end
			default: next_state = VBC_H_IDLE;
		endcase
		next_req_ready = (next_state == VBC_H_IDLE);
	end

	// registers; the read answer is held until the next one
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state <= VBC_H_IDLE;
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			addr_q <= 6'h00;
			data_q <= `VBC_RST_WORD;
			req_ready <= 1'b0;
			rd_word <= `VBC_RST_WORD;
			rd_valid <= 1'b0;
		end else begin
			state <= next_state;
			wr_q <= next_wr_q;
			rd_q <= next_rd_q;
			addr_q <= next_addr_q;
			data_q <= next_data_q;
			req_ready <= next_req_ready;
			rd_valid <= bus.rvalid;
			if (bus.rvalid) begin
				rd_word <= bus.rdata;
			end
		end
	end
endmodule // vbc_host
`default_nettype wire

//--- hdl/vbc_link_if.sv
/*
 * register port between the host end and the synthesizer end.
 * assumes one shared clock; writes and reads are one-cycle strobes.
 */
`timescale 1ns/100ps
`default_nettype none
interface vbc_link_if;
	logic wr_stb;
	logic rd_stb;
	vbc_pkg::vbc_addr_type addr;
	vbc_pkg::vbc_word_type wdata;
	vbc_pkg::vbc_word_type rdata;
	logic rvalid;
	modport dev (input wr_stb, rd_stb, addr, wdata, output rdata, rvalid);
	modport host (output wr_stb, rd_stb, addr, wdata, input rdata, rvalid);
endinterface
`default_nettype wire

//--- hdl/vbc_pkg.sv
/*
 * types shared by both ends of the vco band calibration pair.
 * assumes vbc_cfg.svh is compiled alongside.
 */
package vbc_pkg;
	// calibration engine states
	typedef enum logic [2:0] {
		VBC_IDLE, VBC_WAIT, VBC_SEND, VBC_MEAS, VBC_DECIDE
	} vbc_state_type;
	// host sequencer states
	typedef enum logic [2:0] {
		VBC_H_IDLE, VBC_H_SW, VBC_H_INT, VBC_H_FRAC, VBC_H_RAW
	} vbc_hstate_type;
	typedef logic [5:0] vbc_addr_type;
	typedef logic [23:0] vbc_word_type;
endpackage
